// ---- rtl/pmwc_pkg.sv ----
/*
 * Constants for the power-management and wake control block.
 * Assumes a 200 MHz system clock and a byte-addressed Avalon-MM register slave.
 */
package pmwc_pkg;
	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] PMWC_ADDR_BYTE_TEST = 8'h64;
	localparam logic [7:0] PMWC_ADDR_HWCONF = 8'h74;
	localparam logic [7:0] PMWC_ADDR_PM_CTRL = 8'h84;
	localparam logic [7:0] PMWC_ADDR_EVENT_CLR = 8'hA0;
	// ------------------------------------------------------------
	// Field positions of power_mgmt_control
	// ------------------------------------------------------------
	localparam int PMWC_B_MODE_LO = 12;
	localparam int PMWC_B_XRST = 10;
	localparam int PMWC_B_LWAKE_EN = 9;
	localparam int PMWC_B_EDET_EN = 8;
	localparam int PMWC_B_BUF_TYPE = 6;
	localparam int PMWC_B_CAUSE_LO = 4;
	localparam int PMWC_B_PULSE = 3;
	localparam int PMWC_B_POL = 2;
	localparam int PMWC_B_PIN_EN = 1;
	localparam int PMWC_B_READY = 0;
	// ------------------------------------------------------------
	// Encodings and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] PMWC_MODE_NORMAL = 2'h0;
	localparam logic [1:0] PMWC_MODE_WAKE_FRAME = 2'h1;
	localparam logic [1:0] PMWC_MODE_ENERGY = 2'h2;
	localparam logic [1:0] PMWC_CAUSE_NONE = 2'h0;
	localparam logic [1:0] PMWC_CAUSE_ENERGY = 2'h1;
	localparam logic [1:0] PMWC_CAUSE_LAN = 2'h2;
	localparam logic [1:0] PMWC_CAUSE_MULTI = 2'h3;
	localparam logic [31:0] PMWC_HWCONF_RESET = 32'h00000000;
	localparam logic [31:0] PMWC_BYTE_TEST_VALUE = 32'h87654321;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int PMWC_CLK_MHZ = 200;
	localparam int PMWC_XRST_US = 100;
	localparam int PMWC_XRST_CYCLES = PMWC_XRST_US * PMWC_CLK_MHZ;
	localparam int PMWC_PULSE_MS = 50;
	localparam int PMWC_PULSE_CYCLES = PMWC_PULSE_MS * 1000 * PMWC_CLK_MHZ;
	localparam int PMWC_SETTLE_CYCLES = 64;
	localparam int PMWC_CNT_W = 24;

	typedef enum logic [2:0] {
		PMWC_ST_NORMAL = 3'b001,
		PMWC_ST_SLEEP = 3'b010,
		PMWC_ST_SETTLE = 3'b100
	} pmwc_state_t;
endpackage

// ---- rtl/pmwc_timer.sv ----
/*
 * Load-and-run down counter; busy while counting.
 * Assumes load is a one-cycle strobe from the same clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module pmwc_timer #(
	parameter int W = 24
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic load,
	input wire logic [W-1:0] count,
	input wire logic stop,
	output logic busy,
	output logic done
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				cnt_q <= count;
				busy <= 1'b1;
			end else if (stop) begin
				busy <= 1'b0;
			end else if (busy) begin
				if (cnt_q <= W'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_q <= cnt_q - W'(1);
				end
			end
		end
	end
endmodule // pmwc_timer
`default_nettype wire

// ---- rtl/pmwc_top.sv ----
/*
 * Power-management control register, transceiver reset timer, wake-cause
 * capture and wake pin driver, behind an Avalon-MM slave.
 * Assumes wake event inputs are asynchronous levels from the detectors.
 */
// Summary of operation
// [R1] Mode field: 00 normal, 01 wake-frame sleep, 10 energy sleep, 11 reserved.
// [R2] Any write to the byte-order test register wakes a sleeping device.
// [R3] Host writes only the byte-order test register while not ready.
// [R4] Writing 1 to bit 10 holds transceiver reset 100us, then clears.
// [R5] Writes to bit 10 are ignored while it reads high.
// [R6] Enabled LAN wake event raises irq; pin too when pin enabled.
// [R7] Enabled energy-detect event raises irq; pin too when pin enabled.
// [R8] Bit 6 clear: open-drain active low; set: push-pull.
// [R9] Cause field: 00 none, 01 energy, 10 LAN wake, 11 multiple.
// [R10] Cause bits clear by writing 1, only when ready and sources quiet.
// [R11] Bit 3 set pulses pin 50ms; clear drives it continuously.
// [R12] Pin drops when cause cleared or relevant enable cleared.
// [R13] Push-pull: bit 2 set active high, clear active low.
// [R14] Bit 1 enables the pin only; irq unaffected.
// [R15] Bit 0 read-only ready: device stable and accessible.
// [R16] Control register stays readable in every power state.
// [R17] Host reads only config and control registers while not ready.
// [R18] Host reads once after power-up, reset or wake before writing.
// [R19] Ready clears on sleep entry, sets after wake settles.
`timescale 1ns/10ps
`default_nettype none
module pmwc_top
	import pmwc_pkg::*;
#(
	parameter int XRST_CYCLES = PMWC_XRST_CYCLES,
	parameter int PULSE_CYCLES = PMWC_PULSE_CYCLES,
	parameter int SETTLE_CYCLES = PMWC_SETTLE_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic lan_wake_event,
	input wire logic energy_detect_event,
	output logic transceiver_reset,
	output logic wake_event_irq,
	output logic wake_event_pin_out,
	output logic wake_event_pin_oe_n,
	output logic [1:0] power_state_out
);
	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [1:0] lan_sync_q;
	logic [1:0] ed_sync_q;
	logic lan_ev;
	logic ed_ev;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lan_sync_q <= 2'h0;
			ed_sync_q <= 2'h0;
		end else begin
			lan_sync_q <= {lan_sync_q[0], lan_wake_event};
			ed_sync_q <= {ed_sync_q[0], energy_detect_event};
		end
	end
	assign lan_ev = lan_sync_q[1];
	assign ed_ev = ed_sync_q[1];

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// One wait cycle per access: waitrequest low on the second cycle.
	logic ack_q;
	logic wr_go;
	logic rd_go;
	logic sel_ctrl;
	logic sel_test;
	logic armed_q;
	logic ready_q;
	pmwc_state_t state_q;

	assign wr_go = avs_write & ack_q;
	assign rd_go = avs_read & ack_q;
	assign sel_ctrl = avs_address == PMWC_ADDR_PM_CTRL;
	assign sel_test = avs_address == PMWC_ADDR_BYTE_TEST;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
			avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
		end
	end

	// Writes other than the wake write are dead until a read arms them
	logic wr_ok;
	assign wr_ok = wr_go & armed_q & ready_q & avs_byteenable[0] & avs_byteenable[1]; // [R18]

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (state_q != PMWC_ST_NORMAL) begin
			armed_q <= 1'b0;
		end else if (rd_go) begin
			armed_q <= 1'b1; // [R18]
		end
	end

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	logic [1:0] mode_q;
	logic lwake_en_q;
	logic edet_en_q;
	logic buf_type_q;
	logic pulse_q;
	logic pol_q;
	logic pin_en_q;
	logic xrst_busy;
	logic xrst_load;
	logic ctrl_wr;

	assign ctrl_wr = wr_ok & sel_ctrl;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lwake_en_q <= 1'b0;
			edet_en_q <= 1'b0;
			buf_type_q <= 1'b0;
			pulse_q <= 1'b0;
			pol_q <= 1'b0;
			pin_en_q <= 1'b0;
		end else if (ctrl_wr) begin
			lwake_en_q <= avs_writedata[PMWC_B_LWAKE_EN];
			edet_en_q <= avs_writedata[PMWC_B_EDET_EN];
			buf_type_q <= avs_writedata[PMWC_B_BUF_TYPE];
			pulse_q <= avs_writedata[PMWC_B_PULSE];
			pol_q <= avs_writedata[PMWC_B_POL];
			pin_en_q <= avs_writedata[PMWC_B_PIN_EN];
		end
	end

	// Reserved mode 11 is refused and leaves the mode unchanged
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_q <= PMWC_MODE_NORMAL;
		end else if (state_q == PMWC_ST_SETTLE) begin
			mode_q <= PMWC_MODE_NORMAL; // [R2]
		end else if (ctrl_wr && avs_writedata[PMWC_B_MODE_LO +: 2] != 2'h3) begin
			mode_q <= avs_writedata[PMWC_B_MODE_LO +: 2]; // [R1]
		end
	end

	assign xrst_load = ctrl_wr & avs_writedata[PMWC_B_XRST] & ~xrst_busy; // [R4] [R5]

	pmwc_timer #(
		.W(PMWC_CNT_W)
	) u_xrst_timer (
		.clock(clock),
		.rst(rst),
		.load(xrst_load),
		.count(PMWC_CNT_W'(XRST_CYCLES)),
		.stop(1'b0),
		.busy(xrst_busy),
		.done()
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			transceiver_reset <= 1'b0;
		end else begin
			transceiver_reset <= xrst_busy | xrst_load; // [R4]
		end
	end

	// ------------------------------------------------------------
	// Power state sequencing
	// ------------------------------------------------------------
	logic [PMWC_CNT_W-1:0] settle_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= PMWC_ST_SETTLE;
			settle_q <= '0;
		end else begin
			unique case (state_q)
				PMWC_ST_NORMAL: begin
					if (ctrl_wr && avs_writedata[PMWC_B_MODE_LO +: 2] != PMWC_MODE_NORMAL
						&& avs_writedata[PMWC_B_MODE_LO +: 2] != 2'h3) begin
						state_q <= PMWC_ST_SLEEP;
					end
				end
				PMWC_ST_SLEEP: begin
					// Only the wake write gets through while asleep
					if (wr_go && sel_test) begin
						state_q <= PMWC_ST_SETTLE; // [R2] [R3]
						settle_q <= '0;
					end
				end
				PMWC_ST_SETTLE: begin
					settle_q <= settle_q + PMWC_CNT_W'(1);
					if (settle_q >= PMWC_CNT_W'(SETTLE_CYCLES)) begin
						state_q <= PMWC_ST_NORMAL;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= (state_q == PMWC_ST_NORMAL) && !(ctrl_wr
				&& avs_writedata[PMWC_B_MODE_LO +: 2] != PMWC_MODE_NORMAL
				&& avs_writedata[PMWC_B_MODE_LO +: 2] != 2'h3); // [R19] [R15]
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			power_state_out <= PMWC_MODE_NORMAL;
		end else begin
			power_state_out <= mode_q;
		end
	end

	// ------------------------------------------------------------
	// Wake cause capture
	// ------------------------------------------------------------
	logic lan_hit;
	logic ed_hit;
	logic [1:0] cause_q;
	logic [1:0] cause_d;
	logic cause_clr_ok;
	logic [1:0] clr_mask;
	logic [1:0] hit_vec;

	assign lan_hit = lwake_en_q & lan_ev;
	assign ed_hit = edet_en_q & ed_ev;
	assign hit_vec = {lan_hit, ed_hit}; // [R9]
	// Clear needs ready and quiet sources; an event in the same cycle wins
	assign cause_clr_ok = ready_q & ~lan_ev & ~ed_ev; // [R10]
	assign clr_mask = (ctrl_wr & cause_clr_ok) ? avs_writedata[PMWC_B_CAUSE_LO +: 2] : 2'h0;

	always_comb begin
		cause_d = (cause_q & ~clr_mask) | hit_vec; // [R10] [R9]
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cause_q <= PMWC_CAUSE_NONE;
		end else begin
			cause_q <= cause_d;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wake_event_irq <= 1'b0;
		end else begin
			// Irq ignores the pin enable
			wake_event_irq <= (cause_d[1] & lwake_en_q) | (cause_d[0] & edet_en_q); // [R6] [R7] [R14]
		end
	end

	// ------------------------------------------------------------
	// Wake pin
	// ------------------------------------------------------------
	logic wake_lvl;
	logic wake_lvl_q;
	logic pulse_busy;
	logic pin_act;

	// Level drops as soon as cause or its enable goes away
	assign wake_lvl = pin_en_q & ((cause_q[1] & lwake_en_q) | (cause_q[0] & edet_en_q)); // [R6] [R7] [R12] [R14]

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wake_lvl_q <= 1'b0;
		end else begin
			wake_lvl_q <= wake_lvl;
		end
	end

	pmwc_timer #(
		.W(PMWC_CNT_W + 4)
	) u_pulse_timer (
		.clock(clock),
		.rst(rst),
		.load(wake_lvl & ~wake_lvl_q),
		.count((PMWC_CNT_W + 4)'(PULSE_CYCLES)),
		.stop(~wake_lvl),
		.busy(pulse_busy),
		.done()
	);

	assign pin_act = pulse_q ? pulse_busy : wake_lvl; // [R11] [R12]

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wake_event_pin_out <= 1'b0;
			wake_event_pin_oe_n <= 1'b1;
		end else if (!buf_type_q) begin
			// Open drain: pull low when active, else release
			wake_event_pin_out <= 1'b0; // [R8]
			wake_event_pin_oe_n <= ~pin_act; // [R8]
		end else begin
			wake_event_pin_out <= pol_q ? pin_act : ~pin_act; // [R13]
			wake_event_pin_oe_n <= 1'b0; // [R8]
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [31:0] ctrl_rd;

	always_comb begin
		ctrl_rd = 32'h00000000;
		ctrl_rd[PMWC_B_MODE_LO +: 2] = mode_q;
		ctrl_rd[PMWC_B_XRST] = xrst_busy;
		ctrl_rd[PMWC_B_LWAKE_EN] = lwake_en_q;
		ctrl_rd[PMWC_B_EDET_EN] = edet_en_q;
		ctrl_rd[PMWC_B_BUF_TYPE] = buf_type_q;
		ctrl_rd[PMWC_B_CAUSE_LO +: 2] = cause_q;
		ctrl_rd[PMWC_B_PULSE] = pulse_q;
		ctrl_rd[PMWC_B_POL] = pol_q;
		ctrl_rd[PMWC_B_PIN_EN] = pin_en_q;
		ctrl_rd[PMWC_B_READY] = ready_q; // [R15]
	end

	// Control register answers in every state; byte-order test register reads its value only when ready; the rest read zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h00000000;
		end else if (avs_read & ~ack_q) begin
			if (sel_ctrl) begin
				avs_readdata <= ctrl_rd; // [R16]
			end else if (avs_address == PMWC_ADDR_HWCONF) begin
				avs_readdata <= PMWC_HWCONF_RESET; // [R17]
			end else if (sel_test && ready_q) begin
				avs_readdata <= PMWC_BYTE_TEST_VALUE;
			end else begin
				avs_readdata <= 32'h00000000;
			end
		end
	end
endmodule // pmwc_top
`default_nettype wire

// ---- verification/pmwc_props.sv ----
/* Port checker for pmwc_top.
 * Assumes one clock and an asynchronous active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module pmwc_props
	import pmwc_pkg::*;
#(
	parameter int XRST_CYCLES = PMWC_XRST_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	input wire logic lan_wake_event,
	input wire logic energy_detect_event,
	input wire logic transceiver_reset,
	input wire logic wake_event_irq,
	input wire logic [1:0] power_state_out
);
	// --------------------------------
	// Helpers and properties
	// --------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic [31:0] xr_cnt_q;
	logic [3:0] ev_age_q;
	wire pm_wr = avs_write && avs_address == PMWC_ADDR_PM_CTRL;
	wire xr_wr = pm_wr && avs_writedata[PMWC_B_XRST];
	always_ff @(posedge clock or posedge rst) begin
		if (rst) xr_cnt_q <= 32'h0;
		else if (transceiver_reset) xr_cnt_q <= xr_cnt_q + 32'h1;
		else xr_cnt_q <= 32'h0;
	end
	// Age saturates so a stale event never excuses an interrupt
	always_ff @(posedge clock or posedge rst) begin
		if (rst) ev_age_q <= 4'hF;
		else if (lan_wake_event || energy_detect_event) ev_age_q <= 4'h0;
		else if (ev_age_q != 4'hF) ev_age_q <= ev_age_q + 4'h1;
	end
	sequence s_req_waiting;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	property p_wait_ans; s_req_waiting |=> !avs_waitrequest; endproperty
	a_wait_ans: assert property (p_wait_ans) else $error("request not answered after one wait cycle");
	property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
	property p_wait_idle; !avs_read && !avs_write |=> avs_waitrequest; endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low while idle");
	property p_xr_hold; $fell(transceiver_reset) |-> xr_cnt_q >= XRST_CYCLES; endproperty
	a_xr_hold: assert property (p_xr_hold) else $error("transceiver reset released early");
	property p_xr_cause; $rose(transceiver_reset) |-> $past(xr_wr) || $past(xr_wr, 2); endproperty
	a_xr_cause: assert property (p_xr_cause) else $error("transceiver reset without a write");
	property p_mode_legal; power_state_out != 2'h3; endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("reserved power state entered");
	property p_mode_cause;
		$changed(power_state_out) && power_state_out != PMWC_MODE_NORMAL |-> $past(pm_wr) || $past(pm_wr, 2);
	endproperty
	a_mode_cause: assert property (p_mode_cause) else $error("power state left normal without a write");
	property p_irq_cause; $rose(wake_event_irq) |-> ev_age_q < 4'h6; endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("wake irq without an event");
	property p_rst_vals;
		$fell(rst) |-> avs_waitrequest && !transceiver_reset && !wake_event_irq && power_state_out == PMWC_MODE_NORMAL;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("wrong values after reset");
endmodule // pmwc_props
bind pmwc_top pmwc_props #(.XRST_CYCLES(XRST_CYCLES)) u_props (.clock(clock), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
	.lan_wake_event(lan_wake_event), .energy_detect_event(energy_detect_event), .transceiver_reset(transceiver_reset),
	.wake_event_irq(wake_event_irq), .power_state_out(power_state_out));
`default_nettype wire

// ---- verification/pmwc_host.sv ----
/* Host bus master model for pmwc_top.
 * Assumes the slave answers with waitrequest low at some later edge. */
`timescale 1ns/10ps
`default_nettype none
module pmwc_host (
	input wire logic clock,
	output var logic [7:0] avs_address,
	output var logic avs_read,
	output var logic avs_write,
	output var logic [31:0] avs_writedata,
	output var logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
	end
	// --------------------------------
	// One access, held until accepted
	// --------------------------------
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		@(posedge clock);
		while (avs_waitrequest !== 1'b0) @(posedge clock);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Released lines carry the inverse so stale values never pass
		avs_address <= ~a;
		avs_writedata <= ~d;
	endtask
endmodule // pmwc_host
`default_nettype wire

// ---- verification/testbench.sv ----
/* Self-checking bench for pmwc_top.
 * Assumes shortened reset, pulse and settle counts set below. */
`timescale 1ns/10ps
`default_nettype none
module testbench
	import pmwc_pkg::*;
;
	localparam int XR = 40;
	localparam int PL = 20;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic lan_wake_event = 1'b0;
	logic energy_detect_event = 1'b0;
	wire [7:0] avs_address;
	wire avs_read, avs_write, avs_waitrequest, transceiver_reset, wake_event_irq, pin_out, pin_oe_n;
	wire [31:0] avs_writedata, avs_readdata;
	wire [3:0] avs_byteenable;
	wire [1:0] power_state_out;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	int i;
	always #2.5 clock = ~clock;
	pmwc_host host (.clock(clock), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	pmwc_top #(.XRST_CYCLES(XR), .PULSE_CYCLES(PL), .SETTLE_CYCLES(4)) dut (.clock(clock), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.lan_wake_event(lan_wake_event), .energy_detect_event(energy_detect_event),
		.transceiver_reset(transceiver_reset), .wake_event_irq(wake_event_irq), .wake_event_pin_out(pin_out),
		.wake_event_pin_oe_n(pin_oe_n), .power_state_out(power_state_out));
	// --------------------------------
	// Tasks
	// --------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		host.acc(1'b0, a, 32'h0, d);
		chk("readdata", e, d);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		host.acc(1'b1, a, d, x);
	endtask
	task automatic evt(input logic l, input logic e);
		@(posedge clock);
		lan_wake_event <= l;
		energy_detect_event <= e;
		repeat (8) @(posedge clock);
	endtask
	// Polling reads also arm writes after reset or wake
	task automatic ready_wait();
		logic [31:0] d;
		d = 32'h0;
		for (int k = 0; k < 40 && d[0] !== 1'b1; k++) host.acc(1'b0, PMWC_ADDR_PM_CTRL, 32'h0, d);
	endtask
	task automatic summarize();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			summarize();
		end
	end
	// --------------------------------
	// Tests
	// --------------------------------
	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		ready_wait();
		rd(PMWC_ADDR_PM_CTRL, 32'h00000001);
		rd(PMWC_ADDR_HWCONF, 32'h00000000);
		rd(PMWC_ADDR_BYTE_TEST, PMWC_BYTE_TEST_VALUE);
		rd(8'hF0, 32'h00000000);
		$display("test reset done");
		wr(PMWC_ADDR_PM_CTRL, 32'h00000400);
		rd(PMWC_ADDR_PM_CTRL, 32'h00000401);
		chk("transceiver_reset", 32'h1, {31'h0, transceiver_reset});
		wr(PMWC_ADDR_PM_CTRL, 32'h00000400);
		rd(PMWC_ADDR_PM_CTRL, 32'h00000401);
		// Next read lands after the first hold; the second write came while busy and did not restart it
		repeat (XR - 8) @(posedge clock);
		rd(PMWC_ADDR_PM_CTRL, 32'h00000001);
		chk("transceiver_reset", 32'h0, {31'h0, transceiver_reset});
		$display("test transceiver reset done");
		wr(PMWC_ADDR_PM_CTRL, 32'h00000246);
		evt(1'b1, 1'b0);
		chk("irq", 32'h1, {31'h0, wake_event_irq});
		chk("pin_out", 32'h1, {31'h0, pin_out});
		chk("pin_oe_n", 32'h0, {31'h0, pin_oe_n});
		rd(PMWC_ADDR_PM_CTRL, 32'h00000267);
		wr(PMWC_ADDR_PM_CTRL, 32'h00000276);
		rd(PMWC_ADDR_PM_CTRL, 32'h00000267);
		evt(1'b0, 1'b0);
		wr(PMWC_ADDR_PM_CTRL, 32'h00000276);
		rd(PMWC_ADDR_PM_CTRL, 32'h00000247);
		chk("irq", 32'h0, {31'h0, wake_event_irq});
		chk("pin_out", 32'h0, {31'h0, pin_out});
		$display("test lan wake done");
		wr(PMWC_ADDR_PM_CTRL, 32'h00000100);
		evt(1'b0, 1'b1);
		chk("irq", 32'h1, {31'h0, wake_event_irq});
		chk("pin_oe_n", 32'h1, {31'h0, pin_oe_n});
		rd(PMWC_ADDR_PM_CTRL, 32'h00000111);
		evt(1'b0, 1'b0);
		wr(PMWC_ADDR_PM_CTRL, 32'h00000130);
		rd(PMWC_ADDR_PM_CTRL, 32'h00000101);
		wr(PMWC_ADDR_PM_CTRL, 32'h00000106);
		evt(1'b0, 1'b1);
		chk("pin_out", 32'h0, {31'h0, pin_out});
		chk("pin_oe_n", 32'h0, {31'h0, pin_oe_n});
		wr(PMWC_ADDR_PM_CTRL, 32'h00000006);
		rd(PMWC_ADDR_PM_CTRL, 32'h00000017);
		chk("pin_oe_n", 32'h1, {31'h0, pin_oe_n});
		evt(1'b0, 1'b0);
		wr(PMWC_ADDR_PM_CTRL, 32'h00000330);
		evt(1'b1, 1'b1);
		rd(PMWC_ADDR_PM_CTRL, 32'h00000331);
		evt(1'b0, 1'b0);
		wr(PMWC_ADDR_PM_CTRL, 32'h00000030);
		rd(PMWC_ADDR_PM_CTRL, 32'h00000001);
		$display("test energy detect done");
		wr(PMWC_ADDR_PM_CTRL, 32'h0000024A);
		evt(1'b1, 1'b0);
		chk("pin_out", 32'h0, {31'h0, pin_out});
		repeat (PL - 6) @(posedge clock);
		chk("pin_out", 32'h0, {31'h0, pin_out});
		repeat (12) @(posedge clock);
		chk("pin_out", 32'h1, {31'h0, pin_out});
		evt(1'b0, 1'b0);
		wr(PMWC_ADDR_PM_CTRL, 32'h0000027A);
		rd(PMWC_ADDR_PM_CTRL, 32'h0000024B);
		$display("test pulse done");
		for (i = 1; i < 3; i++) begin
			wr(PMWC_ADDR_PM_CTRL, {18'h0, i[1:0], 12'h000});
			rd(PMWC_ADDR_PM_CTRL, {18'h0, i[1:0], 12'h000});
			chk("power_state", {30'h0, i[1:0]}, {30'h0, power_state_out});
			wr(PMWC_ADDR_BYTE_TEST, 32'hA5A5A5A5);
			// Ready by now but not yet read, so this write must not land
			repeat (12) @(posedge clock);
			wr(PMWC_ADDR_PM_CTRL, 32'h00000200);
			ready_wait();
			rd(PMWC_ADDR_PM_CTRL, 32'h00000001);
			chk("power_state", 32'h0, {30'h0, power_state_out});
		end
		wr(PMWC_ADDR_PM_CTRL, 32'h00003000);
		rd(PMWC_ADDR_HWCONF, 32'h00000000);
		chk("power_state", 32'h0, {30'h0, power_state_out});
		$display("test power states done");
		summarize();
	end
endmodule // testbench
`default_nettype wire
